/* File: bpt_pkg.sv */
// constants, register map and state type of the bridge pwm timing and current limit block
package bpt_pkg;
	localparam int CLK_NS = 25;
	localparam int T_BASE_CENTRE_NS = 20100;
	localparam int T_BASE_EDGE_NS = 20050;
	localparam int T_CODE_STEP_NS = 800;
	localparam int T_DITHER_UNIT_NS = 200;
	localparam int T_MIN_PERIOD_NS = 18000;
	localparam int T_BLANK_UNIT_NS = 200;
	localparam int T_BLANK_MIN_NS = 1000;
	localparam int T_DWELL0_US = 1000;
	localparam int T_DWELL1_US = 2000;
	localparam int T_DWELL2_US = 5000;
	localparam int T_DWELL3_US = 10000;
	localparam logic [11:0] CYC_BASE_CENTRE = 12'(T_BASE_CENTRE_NS / CLK_NS);
	localparam logic [11:0] CYC_BASE_EDGE = 12'(T_BASE_EDGE_NS / CLK_NS);
	localparam logic [11:0] CYC_CODE_STEP = 12'(T_CODE_STEP_NS / CLK_NS);
	localparam logic [6:0] CYC_DITHER_UNIT = 7'(T_DITHER_UNIT_NS / CLK_NS);
	localparam logic [12:0] CYC_MIN_PERIOD = 13'((T_MIN_PERIOD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [8:0] CYC_BLANK_UNIT = 9'(T_BLANK_UNIT_NS / CLK_NS);
	localparam logic [8:0] CYC_BLANK_MIN = 9'((T_BLANK_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0] BLANK_FIXED_MAX = 5'h3;
	localparam logic [4:0] DEMAND_LOW_FILL = 5'h1f;
	localparam int DWELL_W = 20;
	localparam logic [DWELL_W-1:0] CYC_DWELL0 = DWELL_W'(T_DWELL0_US * 1000 / CLK_NS);
	localparam logic [DWELL_W-1:0] CYC_DWELL1 = DWELL_W'(T_DWELL1_US * 1000 / CLK_NS);
	localparam logic [DWELL_W-1:0] CYC_DWELL2 = DWELL_W'(T_DWELL2_US * 1000 / CLK_NS);
	localparam logic [DWELL_W-1:0] CYC_DWELL3 = DWELL_W'(T_DWELL3_US * 1000 / CLK_NS);
	localparam logic [7:0] SENSE_MV_R0 = 8'd200;
	localparam logic [7:0] SENSE_MV_R1 = 8'd100;
	localparam logic [7:0] SENSE_MV_R2 = 8'd50;
	localparam logic [7:0] SENSE_MV_R3 = 8'd25;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_TIMING = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_LIMIT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// timing register fields
	localparam int TM_ALIGN = 0;
	localparam int TM_CYC_LSB = 1;
	localparam int TM_INC_LSB = 7;
	localparam int TM_DWELL_LSB = 10;
	localparam int TM_STEPS_LSB = 12;
	// limit register fields
	localparam int LM_OFF = 0;
	localparam int LM_CUR_MODE = 1;
	localparam int LM_RANGE_LSB = 2;
	localparam int LM_SCALE_LSB = 4;
	localparam int LM_BLANK_LSB = 9;
	// status register fields
	localparam int ST_FLAG = 0;
	localparam int ST_TRIP = 1;
	localparam int ST_PERIOD_LSB = 4;
	localparam int ST_IDX_LSB = 16;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef struct packed {
		logic align;
		logic [5:0] cyc;
		logic [2:0] inc;
		logic [1:0] dwell;
		logic [3:0] steps;
		logic lim_off;
		logic cur_mode;
		logic [1:0] range;
		logic [4:0] scale;
		logic [4:0] blank;
		logic aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [11:0] cnt;
		logic [11:0] period;
		logic sync;
		logic centre;
		logic [11:0] carrier;
		logic [3:0] idx;
		logic lengthen;
		logic [DWELL_W-1:0] dwell_cnt;
		logic [8:0] blank_cnt;
		logic trip;
		logic [17:0] thresh;
	} bpt_state_t;
endpackage : bpt_pkg

/* File: bpt_timing_limit.sv */
// bridge pwm period generator with frequency dither and cycle-by-cycle current limit
`timescale 1ns/1ps
module bpt_timing_limit import bpt_pkg::*; #(
	parameter logic [DWELL_W-1:0] DWELL0_CYC = CYC_DWELL0,
	parameter logic [DWELL_W-1:0] DWELL1_CYC = CYC_DWELL1,
	parameter logic [DWELL_W-1:0] DWELL2_CYC = CYC_DWELL2,
	parameter logic [DWELL_W-1:0] DWELL3_CYC = CYC_DWELL3
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [9:0] demand_input_value_i,
	input wire logic comp_over_i,
	input wire logic gate_change_i,
	output logic pwm_sync_o,
	output logic pwm_centre_o,
	output logic [11:0] carrier_o,
	output logic [11:0] period_o,
	output logic high_side_off_o,
	output logic [17:0] limit_threshold_o,
	output logic current_limit_active_flag_o
);
	bpt_state_t st_q;
	bpt_state_t st_d;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic [31:0] timing_word(input bpt_state_t s);
		return {16'h0000, s.steps, s.dwell, s.inc, s.cyc, s.align};
	endfunction : timing_word

	function automatic logic [31:0] limit_word(input bpt_state_t s);
		return {18'h0_0000, s.blank, s.scale, s.range, s.cur_mode, s.lim_off};
	endfunction : limit_word

	function automatic logic active_flag(input bpt_state_t s);
		return s.cur_mode ? ~s.trip : s.trip;
	endfunction : active_flag

	function automatic logic [8:0] blank_cycles(input logic [4:0] code);
		if (code <= BLANK_FIXED_MAX) begin
			return CYC_BLANK_MIN;
		end
		return 9'(({4'h0, code} + 9'd2) * CYC_BLANK_UNIT);
	endfunction : blank_cycles

	function automatic logic [7:0] sense_mv(input logic [1:0] range);
		case (range)
			2'b00: return SENSE_MV_R0;
			2'b01: return SENSE_MV_R1;
			2'b10: return SENSE_MV_R2;
			default: return SENSE_MV_R3;
		endcase
	endfunction : sense_mv

	function automatic logic [DWELL_W-1:0] dwell_cycles(input logic [1:0] code);
		case (code)
			2'b00: return DWELL0_CYC;
			2'b01: return DWELL1_CYC;
			2'b10: return DWELL2_CYC;
			default: return DWELL3_CYC;
		endcase
	endfunction : dwell_cycles

	function automatic logic [11:0] base_period(input logic align, input logic [5:0] cyc);
		return (align ? CYC_BASE_EDGE : CYC_BASE_CENTRE) + 12'({6'h00, cyc} * CYC_CODE_STEP);
	endfunction : base_period

	logic bypass;
	assign bypass = st_q.lim_off & ~st_q.cur_mode;

	always_comb begin
		logic [31:0] wword;
		logic [10:0] offset;
		logic [12:0] req;
		logic [11:0] half;
		wword = RST_WORD;
		offset = 11'h000;
		req = 13'h0000;
		half = st_q.period >> 1;
		st_d = st_q;
		st_d.sync = 1'b0;
		st_d.centre = 1'b0;
		// write channels, taken in either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			st_d.w_have = 1'b1;
			st_d.w_data = s_axi_wdata_i;
			st_d.w_strb = s_axi_wstrb_i;
		end
		if (st_q.bvalid && s_axi_bready_i) begin
			st_d.bvalid = 1'b0;
		end
		if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
			st_d.aw_have = 1'b0;
			st_d.w_have = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = RESP_OKAY;
			case (st_q.aw_addr)
				OFS_TIMING: begin
					wword = merge_bytes(timing_word(st_q), st_q.w_data, st_q.w_strb);
					st_d.align = wword[TM_ALIGN];
					st_d.cyc = wword[TM_CYC_LSB +: 6];
					st_d.inc = wword[TM_INC_LSB +: 3];
					st_d.dwell = wword[TM_DWELL_LSB +: 2];
					st_d.steps = wword[TM_STEPS_LSB +: 4];
				end
				OFS_LIMIT: begin
					wword = merge_bytes(limit_word(st_q), st_q.w_data, st_q.w_strb);
					st_d.lim_off = wword[LM_OFF];
					st_d.cur_mode = wword[LM_CUR_MODE];
					st_d.range = wword[LM_RANGE_LSB +: 2];
					st_d.scale = wword[LM_SCALE_LSB +: 5];
					st_d.blank = wword[LM_BLANK_LSB +: 5];
				end
				OFS_STATUS: begin
				end
				default: begin
					st_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		// read channel
		if (st_q.rvalid && s_axi_rready_i) begin
			st_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = RESP_OKAY;
			st_d.rdata = RST_WORD;
			case (s_axi_araddr_i)
				OFS_TIMING: st_d.rdata = timing_word(st_q);
				OFS_LIMIT: st_d.rdata = limit_word(st_q);
				OFS_STATUS: begin
					st_d.rdata[ST_FLAG] = active_flag(st_q);
					st_d.rdata[ST_TRIP] = st_q.trip;
					st_d.rdata[ST_PERIOD_LSB +: 12] = st_q.period;
					st_d.rdata[ST_IDX_LSB +: 4] = st_q.idx;
				end
				default: st_d.rresp = RESP_SLVERR;
			endcase
		end
		// dither sequencer
		if (st_q.steps == 4'h0) begin
			st_d.idx = 4'h0;
			st_d.lengthen = 1'b0;
			st_d.dwell_cnt = '0;
		end else if (st_q.dwell_cnt + 1'b1 >= dwell_cycles(st_q.dwell)) begin
			st_d.dwell_cnt = '0;
			if (!st_q.lengthen) begin
				if (st_q.idx >= st_q.steps) begin
					st_d.lengthen = 1'b1;
					st_d.idx = st_q.idx - 4'h1;
				end else begin
					st_d.idx = st_q.idx + 4'h1;
				end
			end else if (st_q.idx == 4'h0) begin
				st_d.lengthen = 1'b0;
				st_d.idx = 4'h1;
			end else begin
				st_d.idx = st_q.idx - 4'h1;
			end
		end else begin
			st_d.dwell_cnt = st_q.dwell_cnt + 1'b1;
		end
		offset = 11'({7'h00, st_q.idx} * (7'({4'h0, st_q.inc} + 7'd1) * CYC_DITHER_UNIT));
		req = {1'b0, base_period(st_q.align, st_q.cyc)} - {2'b00, offset};
		if (req[12] || req < CYC_MIN_PERIOD) begin
			req = CYC_MIN_PERIOD;
		end
		// blanking and trip qualification
		if (gate_change_i) begin
			st_d.blank_cnt = blank_cycles(st_q.blank);
		end else if (st_q.blank_cnt != 9'h000) begin
			st_d.blank_cnt = st_q.blank_cnt - 9'h001;
			if (st_q.blank_cnt == 9'h001 && comp_over_i && !bypass) begin
				st_d.trip = 1'b1;
			end
		end
		// period counter shared by bridge pwm and current control
		if ({1'b0, st_q.cnt} + 13'h0001 >= {1'b0, st_q.period}) begin
			st_d.cnt = 12'h000;
			st_d.sync = 1'b1;
			st_d.period = req[11:0];
			st_d.trip = 1'b0;
		end else begin
			st_d.cnt = st_q.cnt + 12'h001;
		end
		if (st_q.cnt == half) begin
			st_d.centre = 1'b1;
		end
		if (st_q.align) begin
			st_d.carrier = st_q.cnt;
		end else if (st_q.cnt < half) begin
			st_d.carrier = half - st_q.cnt;
		end else begin
			st_d.carrier = st_q.cnt - half;
		end
		// threshold in units of mV / 1024
		if (st_q.cur_mode) begin
			st_d.thresh = 18'(sense_mv(st_q.range) * {demand_input_value_i[9:5], DEMAND_LOW_FILL});
		end else begin
			st_d.thresh = 18'(sense_mv(st_q.range) * {st_q.scale, 5'h00});
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign s_axi_awready_o = ~st_q.aw_have & ~st_q.bvalid;
	assign s_axi_wready_o = ~st_q.w_have & ~st_q.bvalid;
	assign s_axi_bvalid_o = st_q.bvalid;
	assign s_axi_bresp_o = st_q.bresp;
	assign s_axi_arready_o = ~st_q.rvalid;
	assign s_axi_rvalid_o = st_q.rvalid;
	assign s_axi_rdata_o = st_q.rdata;
	assign s_axi_rresp_o = st_q.rresp;
	assign pwm_sync_o = st_q.sync;
	assign pwm_centre_o = st_q.centre;
	assign carrier_o = st_q.carrier;
	assign period_o = st_q.period;
	assign high_side_off_o = st_q.trip;
	assign limit_threshold_o = st_q.thresh;
	assign current_limit_active_flag_o = active_flag(st_q);

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	period_floor_a: assert property (st_q.sync |-> st_q.period >= 12'(CYC_MIN_PERIOD))
		else $error("pwm period below floor");
	base_period_a: assert property (st_q.steps == 4'h0 && $stable(st_q.steps) && $stable(st_q.align)
		&& $stable(st_q.cyc) && st_q.cnt + 12'h001 >= st_q.period && st_q.period != 12'h000
		|=> st_q.period == $past(base_period(st_q.align, st_q.cyc)))
		else $error("period differs from base with dither off");
	period_wrap_a: assert property (st_q.sync |-> st_q.cnt == 12'h000 ##1 st_q.cnt == 12'h001)
		else $error("counter not restarted at period start");
	trip_clear_a: assert property (st_q.sync |-> !st_q.trip)
		else $error("high sides still off after period start");
	trip_cause_a: assert property ($rose(st_q.trip) |-> $past(comp_over_i) && $past(st_q.blank_cnt) == 9'h001
		&& !$past(gate_change_i))
		else $error("trip without expired blanking and comparator");
	bypass_hold_a: assert property (bypass && !st_q.trip |=> !st_q.trip)
		else $error("trip while limit bypassed");
	blank_load_a: assert property (gate_change_i |=> st_q.blank_cnt == blank_cycles($past(st_q.blank)))
		else $error("blank timer not restarted");
	demand_thresh_a: assert property (st_q.cur_mode && $stable(st_q.cur_mode) && $stable(st_q.range)
		|-> st_q.thresh == 18'(sense_mv(st_q.range) * {$past(demand_input_value_i[9:5]), DEMAND_LOW_FILL}))
		else $error("current mode threshold wrong");
	dither_walk_a: assert property (st_q.steps != 4'h0 && $stable(st_q.steps) && $changed(st_q.idx)
		|-> st_q.idx == $past(st_q.idx) + 4'h1 || st_q.idx + 4'h1 == $past(st_q.idx))
		else $error("dither index jumped");
	flag_mode_a: assert property (st_q.cur_mode && st_q.sync |-> current_limit_active_flag_o)
		else $error("flag low at cycle start in current mode");

	trip_seen_c: cover property ($rose(st_q.trip));
	dither_turn_c: cover property ($rose(st_q.lengthen));
	floor_hit_c: cover property (st_q.sync && st_q.period == 12'(CYC_MIN_PERIOD));
	write_read_c: cover property (st_q.bvalid ##[1:20] st_q.rvalid);
endmodule : bpt_timing_limit

/* File: bpt_bridge_model.sv */
// far side model: bridge gate drives and current-sense comparator
`timescale 1ns/1ps
module bpt_bridge_model (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic pwm_sync_i,
	input wire logic over_i,
	input wire logic spike_i,
	input wire logic restart_i,
	output logic gate_change_o,
	output logic comp_over_o
);
	localparam int GATE_AT = 100;
	int cyc_q;
	// position in the pwm period, restarted by the sync pulse
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) cyc_q <= 0;
		else if (pwm_sync_i) cyc_q <= 1;
		else cyc_q <= cyc_q + 1;
	end
	// gates switch at fixed points; restart adds a second change inside the blank time
	assign gate_change_o = (cyc_q == GATE_AT) || (restart_i && cyc_q == GATE_AT + 10);
	// a spike only lasts a few cycles after the gate change
	assign comp_over_o = over_i && !(spike_i && (cyc_q < GATE_AT || cyc_q > GATE_AT + 5));
endmodule : bpt_bridge_model

/* File: bpt_timing_limit_test.sv */
// self-checking bench of the bridge pwm timing and current limit block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module bpt_timing_limit_test import bpt_pkg::*; ();
	logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ov = 0, sp = 0, rs = 0, hp = 0, cm = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic [9:0] di = 0;
	wire logic awr, wr_r, bv, arr, rv, gc, co, sy, ce, hso, fl;
	wire logic [1:0] br, rr;
	wire logic [31:0] rd;
	wire logic [11:0] car, per;
	wire logic [17:0] thr;
	int n_errors = 0, n_tests = 0, cnt = 0, lastp = 0, gcnt = 0, ntrip = 0, exb = -1;
	logic [7:0] mv [4] = '{SENSE_MV_R0, SENSE_MV_R1, SENSE_MV_R2, SENSE_MV_R3};
	bpt_timing_limit #(.DWELL0_CYC(20'h0_07d0), .DWELL1_CYC(20'h0_07d0), .DWELL2_CYC(20'h0_07d0),
		.DWELL3_CYC(20'h0_07d0)) i_bpt_timing_limit (.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
		.demand_input_value_i(di), .comp_over_i(co), .gate_change_i(gc), .pwm_sync_o(sy),
		.pwm_centre_o(ce), .carrier_o(car), .period_o(per), .high_side_off_o(hso),
		.limit_threshold_o(thr), .current_limit_active_flag_o(fl));
	bpt_bridge_model i_bpt_bridge_model (.sys_clk_i(clk), .rst_i(rst), .pwm_sync_i(sy), .over_i(ov),
		.spike_i(sp), .restart_i(rs), .gate_change_o(gc), .comp_over_o(co));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic give_verdict();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic pa, pw;
		@(posedge clk);
		pa = 1;
		pw = 1;
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		repeat (50) begin
			@(posedge clk);
			if (pa && awr) begin pa = 0; awv <= 0; end
			if (pw && wr_r) begin pw = 0; wv <= 0; end
			if (bv) begin `CHK(br, e) bry <= 0; return; end
		end
		`CHK(1'b0, 1'b1)
	endtask : wr
	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
		logic pa;
		@(posedge clk);
		pa = 1;
		d = 'x;
		e = 'x;
		ara <= a;
		arv <= 1;
		rry <= 1;
		repeat (50) begin
			@(posedge clk);
			if (pa && arr) begin pa = 0; arv <= 0; end
			if (rv) begin d = rd; e = rr; rry <= 0; return; end
		end
		`CHK(1'b0, 1'b1)
	endtask : rdr
	task automatic wsy(input int n);
		repeat (n) begin
			@(posedge clk);
			while (!sy) @(posedge clk);
		end
	endtask : wsy
	// one limit setting: count trips over two periods with the comparator over threshold
	task automatic trp(input logic [31:0] v, input int e, input logic s, input logic r, input logic c);
		int nt;
		ov <= 0;
		wr(OFS_LIMIT, v, RESP_OKAY);
		wsy(1);
		exb = e;
		cm = c;
		sp <= s;
		rs <= r;
		ov <= 1;
		nt = ntrip;
		wsy(2);
		ov <= 0;
		`CHK(ntrip - nt, e < 0 ? 0 : 2)
	endtask : trp
	// period, centre pulse and trip timing monitor
	always @(posedge clk) begin
		if (rst) begin
			lastp = 0;
			hp = 0;
		end else begin
			cnt++;
			gcnt++;
			if (gc) gcnt = 0;
			if (ce && lastp != 0) `CHK(cnt, lastp / 2 + 1)
			if (sy) begin
				if (lastp != 0) `CHK(cnt, lastp)
				if (hp) `CHK(hso, 1'b0)
				lastp = per;
				cnt = 0;
			end
			if (hso && !hp) begin ntrip++; `CHK(gcnt, exb) `CHK(fl, !cm) end
			hp = hso;
		end
	end
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		give_verdict();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] e;
		int mn, mx;
		logic [11:0] base;
		repeat (16) @(posedge clk);
		`CHK(per, 12'h000)
		rst <= 0;
		wsy(2);
		`CHK(per, CYC_BASE_CENTRE)
		rdr(8'h0c, d, e);
		`CHK({d, e}, {32'h0000_0000, RESP_SLVERR})
		wr(8'h0c, 32'h0000_0001, RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_TIMING, 32'(i % 2) | 32'(i * 21) << 1, RESP_OKAY);
			wsy(2);
			`CHK(per, (i % 2 ? CYC_BASE_EDGE : CYC_BASE_CENTRE) + CYC_CODE_STEP * 12'(i * 21))
			do @(posedge clk); while (!ce);
			`CHK(car, i % 2 ? 12'(lastp / 2) : 12'h000)
		end
		rdr(OFS_TIMING, d, e);
		`CHK(d, 32'h0000_007f)
		rdr(OFS_STATUS, d, e);
		`CHK(d[15:4], CYC_BASE_EDGE + CYC_CODE_STEP * 12'd63)
		wr(OFS_TIMING, 32'h0000_3094, RESP_OKAY);
		base = CYC_BASE_CENTRE + CYC_CODE_STEP * 12'd10;
		wsy(1);
		mn = 4095;
		mx = 0;
		repeat (16) begin
			wsy(1);
			mn = per < mn ? per : mn;
			mx = per > mx ? per : mx;
		end
		`CHK(12'(mx), base)
		`CHK(12'(mn), base - 12'(6 * CYC_DITHER_UNIT))
		wr(OFS_TIMING, 32'h0000_f380, RESP_OKAY);
		wsy(1);
		mn = 4095;
		repeat (12) begin
			wsy(1);
			mn = per < mn ? per : mn;
		end
		`CHK(13'(mn), CYC_MIN_PERIOD)
		wr(OFS_TIMING, 32'h0000_0380, RESP_OKAY);
		wsy(2);
		repeat (3) begin
			wsy(1);
			`CHK(per, CYC_BASE_CENTRE)
		end
		for (int r = 0; r < 4; r++) begin
			wr(OFS_LIMIT, 32'(r) << 2 | 32'h0000_0100, RESP_OKAY);
			repeat (3) @(posedge clk);
			`CHK(thr, 18'(mv[r] * 512))
			wr(OFS_LIMIT, 32'(r) << 2 | 32'h0000_0002, RESP_OKAY);
			di <= 10'h100 | 10'(r * 7);
			repeat (3) @(posedge clk);
			`CHK(thr, 18'(mv[r] * 287))
		end
		trp(32'h0000_01f0, int'(CYC_BLANK_MIN) + 1, 0, 0, 0);
		trp(32'h0000_07f0, int'(CYC_BLANK_MIN) + 1, 0, 0, 0);
		trp(32'h0000_09f0, int'(CYC_BLANK_UNIT) * 6 + 1, 0, 0, 0);
		trp(32'h0000_2df0, int'(CYC_BLANK_UNIT) * 24 + 1, 0, 0, 0);
		trp(32'h0000_09f0, int'(CYC_BLANK_UNIT) * 6 + 1, 0, 1, 0);
		trp(32'h0000_09f0, -1, 1, 0, 0);
		trp(32'h0000_09f1, -1, 0, 0, 0);
		trp(32'h0000_0802, int'(CYC_BLANK_UNIT) * 6 + 1, 0, 0, 1);
		wsy(1);
		rdr(OFS_STATUS, d, e);
		`CHK(d[0], 1'b1)
		give_verdict();
	end
endmodule : bpt_timing_limit_test
